//--- logic/sbii_params.svh
// Constants for the tag bus codec and the external interrupt path.
// Assumes inclusion by bare name from any design file that needs them.
`ifndef SBII_PARAMS_SVH
`define SBII_PARAMS_SVH

`define SBII_TAG_W        9
`define SBII_AD_W         32
`define SBII_CHK_W        4
`define SBII_TAG_KIND     8
`define SBII_TAG_MORE     7
`define SBII_TAG_NRESP    6
`define SBII_TAG_BAD      5
`define SBII_TAG_NCHK     4
`define SBII_CMD_HI       7
`define SBII_CMD_LO       5
`define SBII_NULL_HI      4
`define SBII_NULL_LO      3
`define SBII_CMD_READ     3'h0
`define SBII_CMD_WRITE    3'h2
`define SBII_CMD_NULL     3'h3
`define SBII_NULL_REL     2'h0
`define SBII_RSV_ONES     4'hf
`define SBII_SEL_HI       6
`define SBII_SEL_LO       4
`define SBII_IRQ_REG_SEL  3'h0
`define SBII_IRQ_W        7
`define SBII_IRQ_RST      7'h00
`define SBII_IRQ_EN_LO    16
`define SBII_IRQ_VAL_LO   0
`define SBII_NMI_BIT      6
`define SBII_HW5_BIT      5
`define SBII_PEND_W       8
`define SBII_PIN_IRQ_W    6
`define SBII_SW_IRQ_W     2

`endif

//--- logic/sbii_pkg.sv
// Types shared by the tag bus and interrupt logic.
// Assumes sbii_params.svh for widths.
`include "sbii_params.svh"

package sbii_pkg;

  typedef enum logic [1:0] {
    SBII_MASTER = 2'h0,
    SBII_SLAVE  = 2'h1,
    SBII_WDATA  = 2'h3,
    SBII_RRESP  = 2'h2
  } sbii_state_t;

  // Data identifier layout, bit 8 down to bit 0
  typedef struct packed {
    logic       kind;
    logic       more;
    logic       not_resp;
    logic       bad;
    logic       no_chk;
    logic [3:0] rsv;
  } sbii_data_id_t;

endpackage

//--- logic/sbii_sync.sv
// Two-flop synchroniser for pins from outside the core clock domain.
// Assumes reset value INIT matches the idle level of the pins.
`timescale 1ns/1ns
`default_nettype none

module sbii_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         core_clk_in,
  input  wire logic         rst_b_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta_q;

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_q <= INIT;
      q_out  <= INIT;
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end

endmodule

`default_nettype wire

//--- logic/sbii_bytepar.sv
// Even parity, one check bit per byte of a bus word.
// Assumes a combinational use on same-clock data.
`timescale 1ns/1ns
`default_nettype none

module sbii_bytepar (
  input  wire logic [31:0] data_in,
  output logic      [3:0]  par_out
);

  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_byte
      // Bit set when byte has odd ones, so the total is even
      assign par_out[i] = ^data_in[8*i +: 8];
    end
  endgenerate

endmodule

`default_nettype wire

//--- logic/sbii_top.sv
// Tag bus identifier codec, external request decode and interrupt merge.
// Assumes pins come from outside; core-side inputs share core_clk_in.
`timescale 1ns/1ns
`default_nettype none
`include "sbii_params.svh"

module sbii_top (
  input  wire logic                     core_clk_in,
  input  wire logic                     rst_b_in,
  input  wire logic [`SBII_TAG_W-1:0]   tag_bus_in,
  output logic      [`SBII_TAG_W-1:0]   tag_bus_out,
  output logic                          tag_bus_oe_out,
  input  wire logic [`SBII_AD_W-1:0]    muxed_addr_data_bus_in,
  output logic      [`SBII_AD_W-1:0]    muxed_addr_data_bus_out,
  output logic                          muxed_addr_data_bus_oe_out,
  input  wire logic [`SBII_CHK_W-1:0]   check_bits_in,
  output logic      [`SBII_CHK_W-1:0]   check_bits_out,
  input  wire logic                     agent_valid_n_in,
  input  wire logic                     agent_bus_request_n_in,
  output logic                          valid_out_n_out,
  output logic                          release_n_out,
  input  wire logic                     tx_req_in,
  input  wire logic [`SBII_AD_W-1:0]    tx_data_in,
  input  wire logic                     tx_last_in,
  input  wire logic                     tx_pcache_perr_in,
  output logic                          tx_ack_out,
  input  wire logic [`SBII_PIN_IRQ_W-1:0] irq_pins_n_in,
  input  wire logic                     nmi_n_in,
  input  wire logic                     tick_irq_in,
  input  wire logic                     tick_sel_in,
  input  wire logic [`SBII_SW_IRQ_W-1:0] sw_irq_in,
  input  wire logic [`SBII_PEND_W-1:0]  mask_bits_in,
  input  wire logic                     global_irq_gate_in,
  output logic      [`SBII_PEND_W-1:0]  pending_bits_out,
  output logic                          cpu_irq_out,
  output logic                          nmi_out,
  output logic                          bus_err_out,
  output logic                          parity_err_out,
  output logic                          align_err_out
);

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  localparam int RXW = `SBII_TAG_W + `SBII_AD_W + `SBII_CHK_W;

  logic [RXW-1:0]                 rx_s;
  logic [`SBII_TAG_W-1:0]         tag_s;
  logic [`SBII_AD_W-1:0]          ad_s;
  logic [`SBII_CHK_W-1:0]         chk_s;
  logic                           valid_n_s;
  logic                           req_n_s;
  logic                           nmi_n_s;
  logic [`SBII_PIN_IRQ_W-1:0]     pins_n_s;

  sbii_sync #(.W(RXW), .INIT('0)) u_sync_bus (
    .core_clk_in (core_clk_in),
    .rst_b_in    (rst_b_in),
    .d_in        ({tag_bus_in, muxed_addr_data_bus_in, check_bits_in}),
    .q_out       (rx_s)
  );

  // Active-low pins idle high, so reset to ones
  sbii_sync #(.W(9), .INIT(9'h1ff)) u_sync_pin (
    .core_clk_in (core_clk_in),
    .rst_b_in    (rst_b_in),
    .d_in        ({agent_valid_n_in, agent_bus_request_n_in, nmi_n_in, irq_pins_n_in}),
    .q_out       ({valid_n_s, req_n_s, nmi_n_s, pins_n_s})
  );

  assign {tag_s, ad_s, chk_s} = rx_s;

  //////////////////////////////////////////////////////////////////////////////
  // Receive decode

  sbii_pkg::sbii_state_t state_q;
  sbii_pkg::sbii_state_t state_d;

  logic [`SBII_CHK_W-1:0] rx_par;
  logic [`SBII_CHK_W-1:0] tx_par;
  logic [6:0]             addr_q;

  sbii_bytepar u_rx_par (.data_in(ad_s), .par_out(rx_par));
  sbii_bytepar u_tx_par (.data_in(tx_data_in), .par_out(tx_par));

  wire rx_valid   = ~valid_n_s;
  wire rx_cmd     = rx_valid & ~tag_s[`SBII_TAG_KIND];
  wire rx_data    = rx_valid & tag_s[`SBII_TAG_KIND];
  wire [2:0] cmd  = tag_s[`SBII_CMD_HI:`SBII_CMD_LO];
  wire is_read    = rx_cmd & (cmd == `SBII_CMD_READ);
  wire is_write   = rx_cmd & (cmd == `SBII_CMD_WRITE);
  // Reserved null attributes are ignored, the agent keeps the bus
  wire is_release = rx_cmd & (cmd == `SBII_CMD_NULL)
                  & (tag_s[`SBII_NULL_HI:`SBII_NULL_LO] == `SBII_NULL_REL);
  // Only word access is supported from outside
  wire misalign   = (is_read | is_write) & (ad_s[1:0] != 2'h0);
  wire rx_bad     = rx_data & tag_s[`SBII_TAG_BAD];
  // Bit 3 and bits 2:0 are reserved and never looked at
  wire rx_par_bad = rx_data & ~tag_s[`SBII_TAG_NCHK] & (rx_par != chk_s);
  wire irq_hit    = (addr_q[`SBII_SEL_HI:`SBII_SEL_LO] == `SBII_IRQ_REG_SEL);
  wire wr_data    = (state_q == sbii_pkg::SBII_WDATA) & rx_data;
  // Bad data, or data failing a parity check it asked for, never reaches the register
  wire irq_we     = wr_data & irq_hit & ~rx_bad & ~rx_par_bad;
  // Ack is registered, so a request held until ack is seen is not taken twice
  wire tx_take    = (state_q == sbii_pkg::SBII_MASTER) & tx_req_in & ~tx_ack_out;
  wire grant      = (state_q == sbii_pkg::SBII_MASTER) & ~tx_req_in & ~req_n_s;

  always_comb begin
    state_d = state_q;
    case (state_q)
      sbii_pkg::SBII_MASTER: begin
        if (grant) begin
          state_d = sbii_pkg::SBII_SLAVE;
        end
      end
      sbii_pkg::SBII_SLAVE: begin
        if (is_read) begin
          state_d = sbii_pkg::SBII_RRESP;
        end else if (is_write) begin
          state_d = sbii_pkg::SBII_WDATA;
        end else if (is_release) begin
          state_d = sbii_pkg::SBII_MASTER;
        end
      end
      sbii_pkg::SBII_WDATA: begin
        if (rx_data) begin
          state_d = sbii_pkg::SBII_MASTER;
        end
      end
      sbii_pkg::SBII_RRESP: state_d = sbii_pkg::SBII_MASTER;
      default:              state_d = sbii_pkg::SBII_MASTER;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transmit identifiers

  sbii_pkg::sbii_data_id_t tx_id;
  sbii_pkg::sbii_data_id_t rr_id;

  always_comb begin
    tx_id          = '{default: 1'b1};
    tx_id.kind     = 1'b1;
    tx_id.more     = ~tx_last_in;
    tx_id.not_resp = 1'b1;
    tx_id.bad      = tx_pcache_perr_in;
    tx_id.rsv      = `SBII_RSV_ONES;
    rr_id          = tx_id;
    rr_id.more     = 1'b0;
    rr_id.not_resp = 1'b0;
    rr_id.bad      = 1'b1;
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q                    <= sbii_pkg::SBII_MASTER;
      addr_q                     <= 7'h00;
      release_n_out              <= 1'b1;
      valid_out_n_out            <= 1'b1;
      tx_ack_out                 <= 1'b0;
      tag_bus_out                <= 9'h000;
      muxed_addr_data_bus_out    <= 32'h0000_0000;
      check_bits_out             <= 4'h0;
      tag_bus_oe_out             <= 1'b1;
      muxed_addr_data_bus_oe_out <= 1'b1;
    end else begin
      state_q         <= state_d;
      release_n_out   <= ~grant;
      valid_out_n_out <= ~(tx_take | (state_q == sbii_pkg::SBII_RRESP));
      tx_ack_out      <= tx_take;
      if (rx_cmd) begin
        addr_q <= ad_s[6:0];
      end
      if (tx_take) begin
        tag_bus_out             <= tx_id;
        muxed_addr_data_bus_out <= tx_data_in;
        check_bits_out          <= tx_par;
      end else if (state_q == sbii_pkg::SBII_RRESP) begin
        tag_bus_out             <= rr_id;
        muxed_addr_data_bus_out <= 32'h0000_0000;
        check_bits_out          <= 4'h0;
      end
      // Bus stays driven in master state and for the read answer
      tag_bus_oe_out             <= (state_d == sbii_pkg::SBII_MASTER)
                                  | (state_d == sbii_pkg::SBII_RRESP);
      muxed_addr_data_bus_oe_out <= (state_d == sbii_pkg::SBII_MASTER)
                                  | (state_d == sbii_pkg::SBII_RRESP);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt register and merge

  logic [`SBII_IRQ_W-1:0]  irq_q;
  logic                    tick_sel_q;
  logic                    strap_done_q;
  logic                    nmi_lvl_q;
  logic [`SBII_PEND_W-1:0] pend_q;

  wire [`SBII_IRQ_W-1:0] wr_en  = ad_s[`SBII_IRQ_EN_LO +: `SBII_IRQ_W];
  wire [`SBII_IRQ_W-1:0] wr_val = ad_s[`SBII_IRQ_VAL_LO +: `SBII_IRQ_W];
  wire [`SBII_IRQ_W-1:0] irq_d  = (irq_q & ~wr_en) | (wr_val & wr_en);
  wire [4:0] hw_lo   = irq_q[4:0] | ~pins_n_s[4:0];
  wire       hw5     = irq_q[`SBII_HW5_BIT] | ~pins_n_s[`SBII_HW5_BIT];
  wire       src15   = tick_sel_q ? tick_irq_in : hw5;
  wire [`SBII_PEND_W-1:0] pend_d = {src15, hw_lo, sw_irq_in};
  wire       nmi_lvl = irq_q[`SBII_NMI_BIT] | ~nmi_n_s;
  wire       any_irq = |(pend_q & mask_bits_in);

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_q        <= `SBII_IRQ_RST;
      tick_sel_q   <= 1'b0;
      strap_done_q <= 1'b0;
      nmi_lvl_q    <= 1'b0;
      pend_q       <= 8'h00;
    end else begin
      if (irq_we) begin
        irq_q <= irq_d;
      end
      // Strap caught once after release, later changes are ignored
      if (!strap_done_q) begin
        tick_sel_q   <= tick_sel_in;
        strap_done_q <= 1'b1;
      end
      nmi_lvl_q <= nmi_lvl;
      pend_q    <= pend_d;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pending_bits_out <= 8'h00;
      cpu_irq_out      <= 1'b0;
      nmi_out          <= 1'b0;
      bus_err_out      <= 1'b0;
      parity_err_out   <= 1'b0;
      align_err_out    <= 1'b0;
    end else begin
      pending_bits_out <= pend_q;
      cpu_irq_out      <= any_irq & global_irq_gate_in;
      nmi_out          <= nmi_lvl & ~nmi_lvl_q;
      bus_err_out      <= (wr_data & rx_bad) | (state_q == sbii_pkg::SBII_RRESP);
      parity_err_out   <= wr_data & rx_par_bad;
      align_err_out    <= (state_q == sbii_pkg::SBII_SLAVE) & misalign;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);

  property p_tx_kind;
    tx_ack_out |-> tag_bus_out[`SBII_TAG_KIND] && !valid_out_n_out;
  endproperty
  a_tx_kind: assert property (p_tx_kind) else $error("data id without bit 8");

  property p_tx_last;
    tx_take |=> tag_bus_out[`SBII_TAG_MORE] == !$past(tx_last_in);
  endproperty
  a_tx_last: assert property (p_tx_last) else $error("last flag wrong");

  property p_tx_perr;
    tx_take |=> tag_bus_out[`SBII_TAG_BAD] == $past(tx_pcache_perr_in);
  endproperty
  a_tx_perr: assert property (p_tx_perr) else $error("parity error not flagged");

  property p_read_resp;
    state_q == sbii_pkg::SBII_RRESP |=> !valid_out_n_out && tag_bus_out[`SBII_TAG_BAD]
      && !tag_bus_out[`SBII_TAG_NRESP] && bus_err_out && state_q == sbii_pkg::SBII_MASTER;
  endproperty
  a_read_resp: assert property (p_read_resp) else $error("read answer malformed");

  property p_release;
    state_q == sbii_pkg::SBII_SLAVE && is_release |=> state_q == sbii_pkg::SBII_MASTER;
  endproperty
  a_release: assert property (p_release) else $error("null release ignored");

  property p_irq_bit0;
    irq_we && wr_en[0] |=> irq_q[0] == $past(wr_val[0]);
  endproperty
  a_irq_bit0: assert property (p_irq_bit0) else $error("enabled bit not written");

  property p_irq_miss;
    wr_data && !irq_hit |=> $stable(irq_q);
  endproperty
  a_irq_miss: assert property (p_irq_miss) else $error("write outside select hit reg");

  property p_gate;
    !global_irq_gate_in |=> !cpu_irq_out;
  endproperty
  a_gate: assert property (p_gate) else $error("irq passed closed gate");

  property p_mask;
    (pend_q & mask_bits_in) == 8'h00 |=> !cpu_irq_out;
  endproperty
  a_mask: assert property (p_mask) else $error("masked irq passed");

  property p_nmi_edge;
    nmi_out |-> nmi_lvl_q && !$past(nmi_lvl_q);
  endproperty
  a_nmi_edge: assert property (p_nmi_edge) else $error("nmi without edge");

  c_ext_write: cover property (irq_we);
  c_ext_read:  cover property (state_q == sbii_pkg::SBII_RRESP);
  c_tx_data:   cover property (tx_ack_out ##1 !valid_out_n_out);
  c_nmi:       cover property (nmi_out);

endmodule

`default_nettype wire

//--- test/sbii_agent.sv
// External agent model for the tag and address/data pins.
// Assumes the bench merges this drive with the device drive by enable.
`timescale 1ns/1ns
`default_nettype none

module sbii_agent (
  input  wire logic        clk_in,
  input  wire logic        release_n_in,
  output logic      [8:0]  tag_out,
  output logic      [31:0] ad_out,
  output logic      [3:0]  chk_out,
  output logic             valid_n_out,
  output logic             req_n_out,
  output logic             hung_out
);
  initial begin
    tag_out = 9'h1ff;
    ad_out = 32'h0;
    chk_out = 4'h0;
    valid_n_out = 1'b1;
    req_n_out = 1'b1;
    hung_out = 1'b0;
  end

  ////////////////////////////////////////
  // Arb skipped when the interface is already in slave state
  task automatic xfer(input logic arb, input logic [8:0] cmd, input logic [31:0] adr,
                      input logic dph, input logic [8:0] did, input logic [31:0] dat,
                      input logic [3:0] chk);
    int n;
    n = 0;
    @(posedge clk_in);
    if (arb) begin
      req_n_out <= 1'b0;
      while (release_n_in !== 1'b0 && n < 40) begin
        @(posedge clk_in);
        n++;
      end
      if (n >= 40) hung_out <= 1'b1;
      req_n_out <= 1'b1;
    end
    tag_out <= cmd;
    ad_out <= adr;
    valid_n_out <= 1'b0;
    if (dph) begin
      @(posedge clk_in);
      tag_out <= did;
      ad_out <= dat;
      chk_out <= chk;
    end
    @(posedge clk_in);
    valid_n_out <= 1'b1;
    // Released lines must not hold the last value
    tag_out <= ~tag_out;
    ad_out <= ~ad_out;
    chk_out <= ~chk_out;
  endtask
endmodule

`default_nettype wire

//--- test/tb_top.sv
// Self-checking bench for the tag bus codec and interrupt merge.
// Assumes the agent model in sbii_agent.sv and a 25 MHz core clock.
`timescale 1ns/1ns
`default_nettype none
`include "sbii_params.svh"

module tb_top;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [8:0]  tag_o, tag_a, tag_w;
  logic [31:0] ad_o, ad_a, ad_w;
  logic [3:0]  chk_o, chk_a;
  logic        tag_oe, ad_oe, vld_a, req_a, hung;
  logic        vld_o, rel_n, ack, nmi, berr, perr, aerr, cpu_irq;
  logic        tx_req = 1'b0, tx_last = 1'b0, tx_perr = 1'b0;
  logic [31:0] tx_data = 32'h0;
  logic [5:0]  pins_n = 6'h3f;
  logic        nmi_n = 1'b1, gate = 1'b1, tick = 1'b0, tick_sel = 1'b0;
  logic [1:0]  sw = 2'h0;
  logic [7:0]  mask = 8'hff, pend;
  int          miscompares = 0, checked = 0;
  int          n_berr = 0, n_nmi = 0, n_perr = 0, n_aerr = 0;

  always #20 clk = ~clk;
  assign tag_w = tag_oe ? tag_o : tag_a;
  assign ad_w = ad_oe ? ad_o : ad_a;

  sbii_agent u_agent (.clk_in(clk), .release_n_in(rel_n), .tag_out(tag_a), .ad_out(ad_a),
    .chk_out(chk_a), .valid_n_out(vld_a), .req_n_out(req_a), .hung_out(hung));

  sbii_top u_dut (.core_clk_in(clk), .rst_b_in(rst_b), .tag_bus_in(tag_w),
    .tag_bus_out(tag_o), .tag_bus_oe_out(tag_oe), .muxed_addr_data_bus_in(ad_w),
    .muxed_addr_data_bus_out(ad_o), .muxed_addr_data_bus_oe_out(ad_oe),
    .check_bits_in(ad_oe ? chk_o : chk_a), .check_bits_out(chk_o),
    .agent_valid_n_in(vld_a), .agent_bus_request_n_in(req_a), .valid_out_n_out(vld_o),
    .release_n_out(rel_n), .tx_req_in(tx_req), .tx_data_in(tx_data), .tx_last_in(tx_last),
    .tx_pcache_perr_in(tx_perr), .tx_ack_out(ack), .irq_pins_n_in(pins_n),
    .nmi_n_in(nmi_n), .tick_irq_in(tick), .tick_sel_in(tick_sel), .sw_irq_in(sw),
    .mask_bits_in(mask), .global_irq_gate_in(gate), .pending_bits_out(pend),
    .cpu_irq_out(cpu_irq), .nmi_out(nmi), .bus_err_out(berr), .parity_err_out(perr),
    .align_err_out(aerr));

  always @(posedge clk) begin
    if (berr === 1'b1) n_berr++;
    if (nmi === 1'b1) n_nmi++;
    if (perr === 1'b1) n_perr++;
    if (aerr === 1'b1) n_aerr++;
  end

  ////////////////////////////////////////
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic print_verdict;
    // Agent gave up waiting for the grant
    if (hung === 1'b1) miscompares++;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  function automatic logic [3:0] par(input logic [31:0] d);
    return {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
  endfunction

  // Wait at a rising edge until ack or valid_out_n is seen at lvl, bounded
  task automatic wait_for(input bit on_ack, input logic lvl);
    int n;
    n = 0;
    while ((on_ack ? ack : vld_o) !== lvl && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20 || hung === 1'b1) begin
      miscompares++;
      print_verdict;
    end
  endtask

  // Interrupt register write: enables at 22:16, values at 6:0
  task automatic wr(input logic [31:0] a, input logic [8:0] did, input logic [6:0] en,
                    input logic [6:0] v, input logic [3:0] flip);
    logic [31:0] d;
    d = {9'h0, en, 9'h0, v};
    u_agent.xfer(1'b1, 9'h05f, a, 1'b1, did, d, par(d) ^ flip);
    cyc(6);
  endtask

  ////////////////////////////////////////
  task automatic t_reset;
    cmp("pending", 8'h00, pend);
    cmp("cpu_irq", 1'b0, cpu_irq);
    cmp("valid_out_n", 1'b1, vld_o);
    cmp("tag_oe", 1'b1, tag_oe);
    cmp("ad_oe", 1'b1, ad_oe);
  endtask

  task automatic t_irq_write;
    wr(32'h0, 9'h14f, 7'h1f, 7'h15, 4'h0);
    cmp("pending set", 8'h54, pend);
    cmp("cpu_irq", 1'b1, cpu_irq);
    wr(32'h0, 9'h14f, 7'h01, 7'h00, 4'h0);
    cmp("pending clr", 8'h50, pend);
    wr(32'h10, 9'h14f, 7'h7f, 7'h7f, 4'h0);
    cmp("other addr", 8'h50, pend);
    wr(32'h0, 9'h17f, 7'h7f, 7'h7f, 4'h0);
    cmp("bad data", 8'h50, pend);
    cmp("bus_err n", 1, n_berr);
    wr(32'h0, 9'h14f, 7'h7f, 7'h7f, 4'h1);
    cmp("parity blk", 8'h50, pend);
    cmp("parity n", 1, n_perr);
    wr(32'h2, 9'h14f, 7'h00, 7'h00, 4'h0);
    cmp("align n", 1, n_aerr);
  endtask

  task automatic t_pins_mask;
    pins_n <= 6'h1d;
    sw <= 2'h1;
    cyc(6);
    cmp("pins", 8'hd9, pend);
    mask <= 8'h00;
    cyc(4);
    cmp("masked", 1'b0, cpu_irq);
    mask <= 8'h08;
    cyc(4);
    cmp("one bit", 1'b1, cpu_irq);
    gate <= 1'b0;
    cyc(4);
    cmp("gate off", 1'b0, cpu_irq);
    gate <= 1'b1;
    pins_n <= 6'h3f;
  endtask

  task automatic t_read;
    u_agent.xfer(1'b1, 9'h01f, 32'h0, 1'b0, 9'h0, 32'h0, 4'h0);
    wait_for(1'b0, 1'b0);
    cmp("rd tag", 9'h13f, tag_o);
    cmp("rd bus_err", 1'b1, berr);
  endtask

  task automatic t_tx(input logic [31:0] d, input logic l, input logic p, input logic [8:0] t);
    @(posedge clk);
    tx_req <= 1'b1;
    tx_data <= d;
    tx_last <= l;
    tx_perr <= p;
    wait_for(1'b1, 1'b1);
    tx_req <= 1'b0;
    cmp("tx tag", t, tag_o);
    cmp("tx data", d, ad_o);
    cmp("tx chk", par(d), chk_o);
    cmp("tx valid", 1'b0, vld_o);
  endtask

  task automatic t_null;
    u_agent.xfer(1'b1, 9'h06f, 32'h0, 1'b0, 9'h0, 32'h0, 4'h0);
    @(posedge clk);
    tx_req <= 1'b1;
    cyc(8);
    cmp("null rsv", 1'b0, tag_oe);
    u_agent.xfer(1'b0, 9'h067, 32'h0, 1'b0, 9'h0, 32'h0, 4'h0);
    wait_for(1'b1, 1'b1);
    tx_req <= 1'b0;
    cmp("null rel", 1'b1, tag_oe);
    cmp("null rel ad", 1'b1, ad_oe);
  endtask

  task automatic t_nmi;
    nmi_n <= 1'b0;
    cyc(8);
    cmp("nmi pin", 1, n_nmi);
    nmi_n <= 1'b1;
    cyc(4);
    wr(32'h0, 9'h14f, 7'h40, 7'h40, 4'h0);
    cmp("nmi reg", 2, n_nmi);
    wr(32'h0, 9'h14f, 7'h40, 7'h00, 4'h0);
  endtask

  // Second reset with the strap set; later strap changes must not count
  task automatic t_strap;
    sw <= 2'h0;
    rst_b <= 1'b0;
    tick_sel <= 1'b1;
    cyc(3);
    rst_b <= 1'b1;
    cyc(2);
    t_reset;
    tick_sel <= 1'b0;
    tick <= 1'b1;
    pins_n <= 6'h1f;
    cyc(6);
    cmp("tick sel", 8'h80, pend);
    tick <= 1'b0;
    cyc(4);
    cmp("tick off", 8'h00, pend);
    pins_n <= 6'h3f;
  endtask

  ////////////////////////////////////////
  initial begin
    cyc(3);
    rst_b <= 1'b1;
    cyc(2);
    t_reset;
    t_irq_write;
    t_pins_mask;
    t_read;
    t_tx(32'h0102_0380, 1'b1, 1'b0, 9'h15f);
    t_tx(32'hffee_0001, 1'b0, 1'b1, 9'h1ff);
    t_null;
    t_nmi;
    t_strap;
    print_verdict;
  end
endmodule

`default_nettype wire
